// ---- core/sbi_core.sv ----
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module sbi_core
    import sbi_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire sbi_bus_s bus_in,
    output logic [15:0] rdata_out,
    input wire logic sck_in,
    input wire logic sdi_in,
    input wire logic ss_n_in,
    output logic sck_out,
    output logic sck_oe_out,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic irq_out
);
    typedef struct packed {
        logic on;
        logic idle_halt;
        logic [2:0] sel;
        logic master;
        logic idle;
        logic ovr;
        logic [1:0] ists;
        logic [1:0] imask;
        logic [3:0] txc;
        logic [2:0] txw;
        logic [2:0] txr;
        logic [3:0] rxc;
        logic [2:0] rxw;
        logic [2:0] rxr;
        logic busy;
        logic [3:0] bitn;
        logic [15:0] sh_o;
        logic [15:0] sh_i;
        logic sck_d;
        logic mclk;
        logic [7:0] div;
        logic [15:0] rdata;
        logic sdo;
        logic sck_o;
        logic sck_oe;
        logic sdo_oe;
        logic irq;
    } sbi_st_s;

    sbi_st_s st_r;
    sbi_st_s st_nxt;
    logic [15:0] txmem_r [SBI_DEPTH];
    logic [15:0] rxmem_r [SBI_DEPTH];
    sbi_pins_s pin_raw;
    sbi_pins_s pin_s;
    logic run;
    logic sck_now;
    logic rise;
    logic fall;
    logic tx_load;
    logic rx_done;
    logic rx_push;
    logic rx_pop;
    logic tx_push;
    logic ev_buf;
    logic [15:0] stat_word;

    assign pin_raw = '{sck: sck_in, sdi: sdi_in, ss_n: ss_n_in};

    sbi_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .pins_in(pin_raw),
        .pins_out(pin_s)
    );

    function automatic logic [3:0] sbi_inc(input logic [3:0] v);
        sbi_inc = v + 4'h1;
    endfunction

    assign run = st_r.on && !(st_r.idle_halt && st_r.idle);
    assign sck_now = st_r.master ? st_r.mclk : pin_s.sck;
    assign rise = run && sck_now && !st_r.sck_d && (st_r.master || !pin_s.ss_n);
    assign fall = run && !sck_now && st_r.sck_d && (st_r.master || !pin_s.ss_n);
    // shift register loads from fifo when idle
    assign tx_load = run && !st_r.busy && (st_r.txc != 4'h0);
    // slave receives even with nothing queued to send
    assign rx_done = rise && (st_r.busy || !st_r.master) && (st_r.bitn == SBI_BITS - 4'h1);
    assign rx_push = rx_done && (st_r.rxc != SBI_DEPTH_C);
    assign rx_pop = bus_in.rd && bus_in.addr == SBI_OFF_BUF && st_r.rxc != 4'h0;
    assign tx_push = bus_in.wr && bus_in.addr == SBI_OFF_BUF && st_r.txc != SBI_DEPTH_C;

    always_comb begin
        stat_word = SBI_RST_16;
        stat_word[SBI_B_ON] = st_r.on;
        stat_word[SBI_B_IDLE] = st_r.idle_halt;
        stat_word[SBI_B_CNT +: 3] = st_r.master ? st_r.txc[2:0] : st_r.rxc[2:0];
        stat_word[SBI_B_SRE] = !st_r.busy;
        stat_word[SBI_B_OVR] = st_r.ovr;
        stat_word[SBI_B_RXE] = (st_r.rxc == 4'h0);
        stat_word[SBI_B_SEL +: 3] = st_r.sel;
        stat_word[SBI_B_TXF] = (st_r.txc == SBI_DEPTH_C);
        stat_word[SBI_B_RXF] = (st_r.rxc == SBI_DEPTH_C);
    end

    always_comb begin
        logic [3:0] txn;
        logic [3:0] rxn;
        txn = st_r.txc;
        rxn = st_r.rxc;
        unique case (st_r.sel)
            3'b111: ev_buf = tx_push && !tx_load && st_r.txc == SBI_DEPTH_C - 4'h1;
            // tx emptied at last bit in
            3'b110: ev_buf = rx_done && st_r.txc == 4'h0;
            3'b101: ev_buf = rx_done;
            3'b100: ev_buf = tx_load && st_r.txc == SBI_DEPTH_C;
            3'b011: ev_buf = rx_push && !rx_pop && st_r.rxc == SBI_DEPTH_C - 4'h1;
            3'b010: ev_buf = st_r.rxc >= SBI_THREE_Q;
            3'b001: ev_buf = st_r.rxc != 4'h0;
            3'b000: ev_buf = rx_pop && !rx_push && st_r.rxc == 4'h1;
            default: ev_buf = 1'b0;
        endcase
        st_nxt = st_r;
        st_nxt.sck_d = sck_now;
        st_nxt.rdata = SBI_RST_16;
        if (bus_in.rd) begin
            case (bus_in.addr)
                SBI_OFF_STAT: st_nxt.rdata = stat_word;
                SBI_OFF_BUF: st_nxt.rdata = rxmem_r[st_r.rxr];
                SBI_OFF_IRQ_STAT: st_nxt.rdata = {14'h0000, st_r.ists};
                SBI_OFF_IRQ_MASK: st_nxt.rdata = {14'h0000, st_r.imask};
                SBI_OFF_CTRL: st_nxt.rdata = {14'h0000, st_r.idle, st_r.master};
                default: st_nxt.rdata = SBI_RST_16;
            endcase
        end
        if (bus_in.wr) begin
            case (bus_in.addr)
                SBI_OFF_STAT: begin
                    st_nxt.on = bus_in.wdata[SBI_B_ON];
                    st_nxt.idle_halt = bus_in.wdata[SBI_B_IDLE];
                    st_nxt.sel = bus_in.wdata[SBI_B_SEL +: 3];
                    if (!bus_in.wdata[SBI_B_OVR]) begin
                        st_nxt.ovr = 1'b0;
                    end
                end
                SBI_OFF_IRQ_STAT: st_nxt.ists = st_r.ists & ~bus_in.wdata[1:0];
                SBI_OFF_IRQ_MASK: st_nxt.imask = bus_in.wdata[1:0];
                SBI_OFF_CTRL: begin
                    st_nxt.master = bus_in.wdata[SBI_B_MST];
                    st_nxt.idle = bus_in.wdata[SBI_B_IDLE_IN];
                end
                default: st_nxt.rdata = st_nxt.rdata;
            endcase
        end
        if (rx_done && st_r.rxc == SBI_DEPTH_C && !rx_pop) begin
            st_nxt.ovr = 1'b1;
            st_nxt.ists[SBI_I_OVR] = 1'b1;
        end
        if (ev_buf) begin
            st_nxt.ists[SBI_I_BUF] = 1'b1;
        end
        if (tx_push) begin
            st_nxt.txw = st_r.txw + 3'h1;
            txn = sbi_inc(txn);
        end
        if (tx_load) begin
            st_nxt.txr = st_r.txr + 3'h1;
            txn = txn - 4'h1;
            st_nxt.busy = 1'b1;
            st_nxt.bitn = 4'h0;
            st_nxt.sh_o = txmem_r[st_r.txr];
            st_nxt.sdo = txmem_r[st_r.txr][7];
            st_nxt.div = 8'h00;
        end
        if (rx_push) begin
            st_nxt.rxw = st_r.rxw + 3'h1;
            rxn = sbi_inc(rxn);
        end
        if (rx_pop) begin
            st_nxt.rxr = st_r.rxr + 3'h1;
            rxn = rxn - 4'h1;
        end
        st_nxt.txc = txn;
        st_nxt.rxc = rxn;
        // master clock: enable-style divider, idle low
        if (run && st_r.master && st_r.busy) begin
            if (st_r.div == SBI_HALF_CYC - 8'h01) begin
                st_nxt.div = 8'h00;
                st_nxt.mclk = !st_r.mclk;
            end else begin
                st_nxt.div = st_r.div + 8'h01;
            end
        end else if (!tx_load) begin
            st_nxt.mclk = 1'b0;
            st_nxt.div = 8'h00;
        end
        // sample on rising, shift out on falling
        // deselected slave restarts its bit count
        if (!st_r.master && pin_s.ss_n) begin
            st_nxt.bitn = 4'h0;
        end
        if (rise && (st_r.busy || !st_r.master)) begin
            st_nxt.sh_i = {st_r.sh_i[14:0], pin_s.sdi};
            st_nxt.bitn = st_r.bitn + 4'h1;
            if (rx_done) begin
                st_nxt.busy = 1'b0;
            end
        end
        if (fall && st_r.busy) begin
            st_nxt.sh_o = {st_r.sh_o[14:0], 1'b0};
            st_nxt.sdo = st_r.sh_o[6];
        end
        if (!st_r.on) begin
            st_nxt.busy = 1'b0;
            st_nxt.mclk = 1'b0;
        end
        st_nxt.sck_o = st_nxt.mclk;
        st_nxt.sck_oe = st_nxt.on && st_nxt.master;
        st_nxt.sdo_oe = st_nxt.on && (st_nxt.master || !pin_s.ss_n);
        st_nxt.irq = |(st_nxt.ists & st_nxt.imask);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (tx_push) begin
            txmem_r[st_r.txw] <= bus_in.wdata;
        end
        if (rx_push) begin
            rxmem_r[st_r.rxw] <= {8'h00, st_r.sh_i[6:0], pin_s.sdi};
        end
    end

    assign rdata_out = st_r.rdata;
    assign sck_out = st_r.sck_o;
    assign sck_oe_out = st_r.sck_oe;
    assign sdo_out = st_r.sdo;
    assign sdo_oe_out = st_r.sdo_oe;
    assign irq_out = st_r.irq;

    a_full_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (st_r.rxc == SBI_DEPTH_C) |-> stat_word[SBI_B_RXF]) else $error("rx full flag wrong");
    a_ovr_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (rx_done && st_r.rxc == SBI_DEPTH_C && !rx_pop) |=> st_r.ovr) else $error("overrun lost");
    a_ovr_keep: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (rx_done && st_r.rxc == SBI_DEPTH_C && !rx_pop) |=> $stable(st_r.rxc))
        else $error("overrun changed fifo");
    a_rx_empty: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        stat_word[SBI_B_RXE] == (st_r.rxc == 4'h0)) else $error("rx empty flag wrong");
    a_off_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !st_r.on |-> !sck_oe_out && !sdo_oe_out ##1 !st_r.busy) else $error("disabled port active");
    a_idle_stop: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (st_r.idle_halt && st_r.idle) |-> !rise && !tx_load) else $error("ran during idle");
    a_sr_empty: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        tx_load |=> !stat_word[SBI_B_SRE]) else $error("shift empty flag wrong");
    a_irq_out: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (st_r.sel == 3'b001 && st_r.rxc != 4'h0 && st_r.imask[SBI_I_BUF] && !bus_in.wr)
        |-> ##2 irq_out) else $error("data available irq missing");
    a_cnt_mst: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        st_r.master |-> stat_word[SBI_B_CNT +: 3] == st_r.txc[2:0]) else $error("count wrong");
    c_overrun: cover property (@(posedge core_clk_in) st_r.ovr);
    c_rx_full: cover property (@(posedge core_clk_in) st_r.rxc == SBI_DEPTH_C);
    c_irq: cover property (@(posedge core_clk_in) irq_out);
endmodule

// ---- core/sbi_pkg.sv ----
package sbi_pkg;
    // register offsets
    localparam logic [3:0] SBI_OFF_STAT = 4'h0;
    localparam logic [3:0] SBI_OFF_BUF = 4'h1;
    localparam logic [3:0] SBI_OFF_IRQ_STAT = 4'h2;
    localparam logic [3:0] SBI_OFF_IRQ_MASK = 4'h3;
    localparam logic [3:0] SBI_OFF_CTRL = 4'h4;
    // status/control field positions
    localparam int SBI_B_ON = 15;
    localparam int SBI_B_IDLE = 13;
    localparam int SBI_B_CNT = 8;
    localparam int SBI_B_SRE = 7;
    localparam int SBI_B_OVR = 6;
    localparam int SBI_B_RXE = 5;
    localparam int SBI_B_SEL = 2;
    localparam int SBI_B_TXF = 1;
    localparam int SBI_B_RXF = 0;
    // control register field positions
    localparam int SBI_B_MST = 0;
    localparam int SBI_B_IDLE_IN = 1;
    // interrupt status bits
    localparam int SBI_I_BUF = 0;
    localparam int SBI_I_OVR = 1;
    localparam logic [15:0] SBI_RST_16 = 16'h0000;
    localparam int SBI_DEPTH = 8;
    localparam logic [3:0] SBI_DEPTH_C = 4'h8;
    localparam logic [3:0] SBI_THREE_Q = 4'h6;
    localparam logic [3:0] SBI_BITS = 4'h8;
    // clock divider for master serial clock: half period in core cycles
    localparam int SBI_CLK_NS = 5;
    localparam int SBI_SCK_HALF_NS = 80;
    localparam logic [7:0] SBI_HALF_CYC = 8'(SBI_SCK_HALF_NS / SBI_CLK_NS);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } sbi_bus_s;

    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
    } sbi_pins_s;
endpackage

// ---- core/sbi_sync.sv ----
`timescale 1ns/100ps
module sbi_sync
    import sbi_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire sbi_pins_s pins_in,
    output sbi_pins_s pins_out
);
    typedef struct packed {
        sbi_pins_s meta;
        sbi_pins_s sync;
    } sbi_sync_st_s;
    sbi_sync_st_s st_r;
    sbi_sync_st_s st_nxt;

    // second stage alone feeds logic
    always_comb begin
        st_nxt.meta = pins_in;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_r <= '{meta: 3'b001, sync: 3'b001};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins_out = st_r.sync;
endmodule

// ---- test/sbi_far_model.sv ----
`timescale 1ns/100ps
module sbi_far_model (
    input wire logic sck_in,
    input wire logic sdo_in,
    output logic sdi_out,
    output logic [7:0] got_out,
    output logic [7:0] words_out
);
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    initial begin
        sh_r = 8'h5a;
        bit_r = 3'h0;
        got_out = 8'h00;
        words_out = 8'h00;
    end
    assign sdi_out = sh_r[7];
    always @(posedge sck_in) begin
        got_out <= {got_out[6:0], sdo_in};
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7) begin
            words_out <= words_out + 8'h01;
        end
    end
    // inverted fill, so a stale line never looks like data
    always @(negedge sck_in) begin
        sh_r <= (bit_r == 3'h0) ? (8'h5a ^ (words_out * 8'h1d)) : {sh_r[6:0], ~sh_r[7]};
    end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
    import sbi_pkg::*;
();
    localparam logic [7:0] MODE_HIT = 8'h63;
    logic core_clk, rst_n, tb_sck, ss_n, sdi, irq, sck_o, sck_oe, sdo, sdo_oe;
    logic [15:0] rdata, rd_v;
    logic [7:0] got, words, base, txb;
    sbi_bus_s bus;
    wire logic sck_w;
    int error_cnt, checks_done, seed, n, m;
    // pin released by the dut follows the bench clock
    assign sck_w = sck_oe ? sck_o : tb_sck;
    always #2.5 core_clk = ~core_clk;
    sbi_core dut (.core_clk_in(core_clk), .rst_n_in(rst_n), .bus_in(bus), .rdata_out(rdata),
        .sck_in(sck_w), .sdi_in(sdi), .ss_n_in(ss_n), .sck_out(sck_o), .sck_oe_out(sck_oe),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .irq_out(irq));
    sbi_far_model far (.sck_in(sck_w), .sdo_in(sdo), .sdi_out(sdi), .got_out(got),
        .words_out(words));
    function automatic logic [7:0] exp_rx(input logic [7:0] k);
        return 8'h5a ^ (k * 8'h1d);
    endfunction
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus <= '0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        bus <= '0;
        #1 d = rdata;
        @(posedge core_clk);
    endtask
    task automatic wait_idle(input logic [7:0] target);
        for (n = 0; n < 5000; n++) begin
            rd(SBI_OFF_STAT, rd_v);
            if (words === target && rd_v[SBI_B_SRE] === 1'b1 && rd_v[SBI_B_RXE] === 1'b0) break;
        end
        if (n == 5000) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic xfer();
        base = words;
        txb = 8'($random(seed));
        wr(SBI_OFF_BUF, {8'h00, txb});
        wait_idle(base + 8'h01);
        chk({8'h00, got}, {8'h00, txb}, "sent");
    endtask
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        tb_sck = 1'b0;
        ss_n = 1'b1;
        bus = '0;
        error_cnt = 0;
        checks_done = 0;
        seed = 32'hdb79;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(SBI_OFF_STAT, rd_v);
        chk(rd_v, 16'h00a0, "stat_rst");
        chk({14'h0, sck_oe, sdo_oe}, 16'h0000, "oe_off");
        rd(4'hf, rd_v);
        chk(rd_v, 16'h0000, "unmapped");
        wr(SBI_OFF_CTRL, 16'h0001);
        wr(SBI_OFF_IRQ_MASK, 16'h0003);
        // mode 100 runs but is not checked: its free-slot reading is loose
        for (m = 0; m < 8; m++) begin
            wr(SBI_OFF_STAT, 16'h8000 | 16'(m << SBI_B_SEL));
            wr(SBI_OFF_IRQ_STAT, 16'h0003);
            xfer();
            rd(SBI_OFF_BUF, rd_v);
            chk({8'h00, rd_v[7:0]}, {8'h00, exp_rx(base)}, "rx_word");
            rd(SBI_OFF_IRQ_STAT, rd_v);
            if (m != 4) chk({rd_v[0], irq}, {2{MODE_HIT[m]}}, "mode_irq");
        end
        wr(SBI_OFF_CTRL, 16'h0003);
        wr(SBI_OFF_STAT, 16'ha000);
        base = words;
        wr(SBI_OFF_BUF, 16'h00c3);
        repeat (600) @(posedge core_clk);
        rd(SBI_OFF_STAT, rd_v);
        chk({words, 7'h00, rd_v[SBI_B_SRE]}, {base, 8'h01}, "halted");
        wr(SBI_OFF_CTRL, 16'h0001);
        wait_idle(base + 8'h01);
        rd(SBI_OFF_BUF, rd_v);
        chk({8'h00, rd_v[7:0]}, {8'h00, exp_rx(base)}, "resumed");
        wr(SBI_OFF_STAT, 16'h801c);
        wr(SBI_OFF_IRQ_STAT, 16'h0003);
        base = words;
        // ten words: one shifting, eight queued, last refused
        for (m = 0; m < 10; m++) wr(SBI_OFF_BUF, {8'h00, 8'($random(seed))});
        rd(SBI_OFF_STAT, rd_v);
        chk({15'h0, rd_v[SBI_B_TXF]}, 16'h0001, "tx_full");
        wait_idle(base + 8'h09);
        chk(rd_v, 16'h80dd, "stat_full");
        rd(SBI_OFF_IRQ_STAT, rd_v);
        chk(rd_v, 16'h0003, "irq_full");
        wr(SBI_OFF_IRQ_MASK, 16'h0000);
        #1 chk({15'h0, irq}, 16'h0000, "irq_masked");
        wr(SBI_OFF_IRQ_MASK, 16'h0003);
        #1 chk({15'h0, irq}, 16'h0001, "irq_unmasked");
        wr(SBI_OFF_IRQ_STAT, 16'h0003);
        rd(SBI_OFF_IRQ_STAT, rd_v);
        chk({rd_v[14:0], irq}, 16'h0000, "irq_clear");
        for (m = 0; m < 8; m++) begin
            rd(SBI_OFF_BUF, rd_v);
            chk({8'h00, rd_v[7:0]}, {8'h00, exp_rx(base + 8'(m))}, "kept");
        end
        wr(SBI_OFF_STAT, 16'h8003);
        rd(SBI_OFF_STAT, rd_v);
        chk(rd_v, 16'h80a0, "stat_drained");
        wr(SBI_OFF_CTRL, 16'h0000);
        base = words;
        ss_n <= 1'b0;
        for (m = 0; m < 16; m++) begin
            repeat (16) @(posedge core_clk);
            tb_sck <= ~tb_sck;
        end
        repeat (16) @(posedge core_clk);
        chk({15'h0, sdo_oe}, 16'h0001, "sdo_oe");
        ss_n <= 1'b1;
        wait_idle(base + 8'h01);
        chk(rd_v, 16'h8180, "slave_stat");
        rd(SBI_OFF_BUF, rd_v);
        chk({8'h00, rd_v[7:0]}, {8'h00, exp_rx(base)}, "slave_word");
        give_verdict();
    end
endmodule
